/* core/lsp_pkg.sv */
`default_nettype none
package lsp_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] ADDR_ENABLE = 4'h0;
    localparam logic [3:0] ADDR_STBY = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    // regulator indices
    localparam int NREG = 6;
    localparam int IDX_PLL = 0;
    localparam int IDX_DAC = 1;
    localparam int IDX_USB = 2;
    localparam int IDX_AUX = 3;
    localparam int IDX_GEN1 = 4;
    localparam int IDX_GEN2 = 5;
    // regulators that carry short protection
    localparam logic [5:0] PROT_MASK = 6'h3e;
    // regulators with internal pass device only
    localparam logic [5:0] INTERNAL_PASS = 6'h15;
    // control register fields
    localparam int CTRL_PROT_EN = 0;
    localparam int CTRL_IRQ_MASK = 1;
    localparam int CTRL_VSEL_LO = 2;
    localparam int CTRL_LP_LO = 4;
    localparam logic [1:0] VSEL_RESET = 2'h0;
    localparam logic [5:0] ENABLE_RESET = 6'h00;
    // debounce time and derived cycle count at 40 MHz
    localparam int CLK_HZ = 40000000;
    localparam int DEBOUNCE_US = 30;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * (CLK_HZ / 1000000));
    // pll regulator voltage select codes
    typedef enum logic [1:0] {
        lsp_v1p20, lsp_v1p25, lsp_v1p50, lsp_v1p80
    } lsp_vsel_type;
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } lsp_bus_req_type;
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } lsp_bus_rsp_type;
endpackage
`default_nettype wire

/* core/lsp_ldo_ctrl.sv */
`default_nettype none
// Overview of operation
// - Internal-pass regulators switch only on enable, standby select and the standby event.
// - Off when disabled, on when enabled without standby select, off in standby when selected.
// - Five regulators (dac, usb phy, aux usb, two general) each have a fault input.
// - Each fault input is debounced before anything acts on it.
// - A debounced fault with protection enabled clears that regulator's enable bit.
// - The same action sets the sticky short fault flag.
// - The fault flag reaches the interrupt output only while its mask bit is clear.
// - Protection acts only while the global protection enable bit is set.
// - With protection disabled a fault neither clears enables nor raises the flag.
// - The protection enable bit resets to zero.
// - The pll regulator's two-bit voltage select is driven to the analog regulator.
// - Reads return programmed enable, mode and standby bits, not the actual state.
// - Configurable regulators follow their own low-power mode bit.
module lsp_ldo_ctrl
#(
    parameter int DEBOUNCE = lsp_pkg::DEBOUNCE_CYCLES
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // avalon-mm slave
    input wire lsp_pkg::lsp_bus_req_type i_bus,
    output lsp_pkg::lsp_bus_rsp_type o_bus,
    // analog side
    input wire logic i_standby,
    input wire logic [lsp_pkg::NREG-1:0] i_fault,
    output logic [lsp_pkg::NREG-1:0] o_reg_on,
    output logic [lsp_pkg::NREG-1:0] o_low_power,
    output lsp_pkg::lsp_vsel_type o_pll_vsel,
    output logic o_irq
);
    import lsp_pkg::*;

    localparam int CW = $clog2(DEBOUNCE + 1);

    initial
    begin
        if (DEBOUNCE < 1)
            $error("debounce count must be at least one");
    end

    typedef struct packed {
        logic [NREG-1:0] enable;
        logic [NREG-1:0] stby_sel;
        logic [NREG-1:0] lp_mode;
        logic prot_en;
        logic irq_mask;
        logic [1:0] vsel;
        logic [NREG-1:0] fault_flag;
        logic [NREG-1:0][CW-1:0] cnt;
        logic [NREG-1:0] deb;
        logic ack;
        logic [31:0] rdata;
        logic [NREG-1:0] reg_on;
        logic [NREG-1:0] low_power;
    } lsp_state_type;

    lsp_state_type st;
    lsp_state_type next_st;
    logic [NREG-1:0] trip;
    logic req;
    logic wr;

    function automatic logic [31:0] ctrl_word(input lsp_state_type s);
        logic [31:0] w;
        w = '0;
        w[CTRL_PROT_EN] = s.prot_en;
        w[CTRL_IRQ_MASK] = s.irq_mask;
        w[CTRL_VSEL_LO +: 2] = s.vsel;
        w[CTRL_LP_LO +: NREG] = s.lp_mode;
        return w;
    endfunction

    assign req = (i_bus.read | i_bus.write) & ~st.ack;
    // a write lands on the edge that samples waitrequest low, never earlier
    assign wr = i_bus.write & st.ack;

    always_comb
    begin
        next_st = st;
        next_st.ack = req;
        // debounce: count while fault held, clear when it drops
        for (int i = 0; i < NREG; i++)
        begin
            if (!i_fault[i] || !PROT_MASK[i])
                next_st.cnt[i] = '0;
            else if (st.cnt[i] != CW'(DEBOUNCE))
                next_st.cnt[i] = st.cnt[i] + CW'(1);
            next_st.deb[i] = (st.cnt[i] == CW'(DEBOUNCE));
        end
        trip = st.deb & PROT_MASK & st.enable & {NREG{st.prot_en}};
        // software writes
        if (wr)
        begin
            unique case (i_bus.address)
                ADDR_ENABLE: next_st.enable = i_bus.writedata[NREG-1:0];
                ADDR_STBY: next_st.stby_sel = i_bus.writedata[NREG-1:0];
                ADDR_CTRL:
                begin
                    next_st.prot_en = i_bus.writedata[CTRL_PROT_EN];
                    next_st.irq_mask = i_bus.writedata[CTRL_IRQ_MASK];
                    next_st.vsel = i_bus.writedata[CTRL_VSEL_LO +: 2];
                    next_st.lp_mode = i_bus.writedata[CTRL_LP_LO +: NREG];
                end
                // write one to clear; a new trip below still wins
                ADDR_STATUS: next_st.fault_flag = st.fault_flag & ~i_bus.writedata[NREG-1:0];
                default: ;
            endcase
        end
        // protection has priority over a simultaneous software write
        next_st.enable = next_st.enable & ~trip;
        next_st.fault_flag = next_st.fault_flag | trip;
        // read data reflects programmed bits only
        next_st.rdata = '0;
        if (req && i_bus.read)
        begin
            unique case (i_bus.address)
                ADDR_ENABLE: next_st.rdata = 32'(st.enable);
                ADDR_STBY: next_st.rdata = 32'(st.stby_sel);
                ADDR_CTRL: next_st.rdata = ctrl_word(st);
                ADDR_STATUS: next_st.rdata = 32'(st.fault_flag);
                default: next_st.rdata = '0;
            endcase
        end
        // regulator state: enable, and not (standby select during standby)
        next_st.reg_on = next_st.enable & ~(next_st.stby_sel & {NREG{i_standby}});
        // internal-pass regulators ignore the mode bit
        next_st.low_power = next_st.lp_mode & ~INTERNAL_PASS & next_st.reg_on;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st <= '0;
            st.enable <= ENABLE_RESET;
            st.prot_en <= 1'b0;
            st.vsel <= VSEL_RESET;
        end
        else
            st <= next_st;
    end

    assign o_bus.waitrequest = ~st.ack;
    assign o_bus.readdata = st.rdata;
    assign o_reg_on = st.reg_on;
    assign o_low_power = st.low_power;
    assign o_pll_vsel = lsp_vsel_type'(st.vsel);
    assign o_irq = |st.fault_flag & ~st.irq_mask;

    // assertions
    // a debounced trip must shut the regulator and flag it in one edge
    a_trip_clears_en: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.deb[IDX_DAC] && st.prot_en && st.enable[IDX_DAC])
        |=> (!st.enable[IDX_DAC] && st.fault_flag[IDX_DAC]))
        else $error("short did not disable regulator");
    a_trip_clears_usb: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.deb[IDX_USB] && st.prot_en && st.enable[IDX_USB])
        |=> (!st.enable[IDX_USB] && st.fault_flag[IDX_USB]))
        else $error("short did not disable usb phy regulator");
    a_trip_clears_aux: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.deb[IDX_AUX] && st.prot_en && st.enable[IDX_AUX])
        |=> (!st.enable[IDX_AUX] && st.fault_flag[IDX_AUX]))
        else $error("short did not disable aux usb regulator");
    a_trip_clears_gen1: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.deb[IDX_GEN1] && st.prot_en && st.enable[IDX_GEN1])
        |=> (!st.enable[IDX_GEN1] && st.fault_flag[IDX_GEN1]))
        else $error("short did not disable general regulator one");
    a_trip_clears_gen2: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.deb[IDX_GEN2] && st.prot_en && st.enable[IDX_GEN2])
        |=> (!st.enable[IDX_GEN2] && st.fault_flag[IDX_GEN2]))
        else $error("short did not disable general regulator two");

    // software can only clear flags, so a rising flag needs a trip behind it
    a_flag_with_trip: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(st.fault_flag[IDX_USB]) |-> $past(st.deb[IDX_USB] && st.prot_en))
        else $error("fault flag set without debounced trip");
    a_flag_trip_dac: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(st.fault_flag[IDX_DAC]) |-> $past(st.deb[IDX_DAC] && st.prot_en))
        else $error("dac fault flag set without trip");
    a_flag_trip_aux: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(st.fault_flag[IDX_AUX]) |-> $past(st.deb[IDX_AUX] && st.prot_en))
        else $error("aux fault flag set without trip");
    a_flag_trip_gen1: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(st.fault_flag[IDX_GEN1]) |-> $past(st.deb[IDX_GEN1] && st.prot_en))
        else $error("general one fault flag set without trip");
    a_flag_trip_gen2: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(st.fault_flag[IDX_GEN2]) |-> $past(st.deb[IDX_GEN2] && st.prot_en))
        else $error("general two fault flag set without trip");
    a_pll_unguarded: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !st.fault_flag[IDX_PLL] && !st.deb[IDX_PLL])
        else $error("pll regulator took part in short protection");

    a_irq_masked: assert property (@(posedge i_clk) disable iff (!i_resetn)
        st.irq_mask |-> !o_irq)
        else $error("masked interrupt asserted");
    a_irq_unmasked: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!st.irq_mask && |st.fault_flag) |-> o_irq)
        else $error("unmasked fault did not reach interrupt");
    a_no_prot_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!st.prot_en && !wr) |=> ($stable(st.fault_flag) && st.enable == $past(st.enable)))
        else $error("protection acted while disabled");
    a_prot_by_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !(wr && i_bus.address == ADDR_CTRL) |=> $stable(st.prot_en))
        else $error("protection enable changed without a write");

    // the debounced flag lags the raw input by at least two edges
    a_debounce_short: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_fault[IDX_GEN1]) |=> !st.deb[IDX_GEN1] ##1 (DEBOUNCE < 2 || !st.deb[IDX_GEN1]))
        else $error("fault not debounced");
    a_debounce_dac: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_fault[IDX_DAC]) |=> !st.deb[IDX_DAC] ##1 (DEBOUNCE < 2 || !st.deb[IDX_DAC]))
        else $error("dac fault not debounced");
    a_debounce_usb: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_fault[IDX_USB]) |=> !st.deb[IDX_USB] ##1 (DEBOUNCE < 2 || !st.deb[IDX_USB]))
        else $error("usb phy fault not debounced");
    a_debounce_aux: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_fault[IDX_AUX]) |=> !st.deb[IDX_AUX] ##1 (DEBOUNCE < 2 || !st.deb[IDX_AUX]))
        else $error("aux usb fault not debounced");
    a_debounce_gen2: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_fault[IDX_GEN2]) |=> !st.deb[IDX_GEN2] ##1 (DEBOUNCE < 2 || !st.deb[IDX_GEN2]))
        else $error("general two fault not debounced");

    // a write in the same cycle may legally change the select, so it is excluded
    a_standby_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_standby && st.stby_sel[IDX_AUX] && !wr) |=> !o_reg_on[IDX_AUX])
        else $error("regulator on in standby with select");
    a_standby_off_dac: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_standby && st.stby_sel[IDX_DAC] && !wr) |=> !o_reg_on[IDX_DAC])
        else $error("dac regulator on in standby with select");
    a_standby_off_gen2: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_standby && st.stby_sel[IDX_GEN2] && !wr) |=> !o_reg_on[IDX_GEN2])
        else $error("general two regulator on in standby with select");
    a_standby_no_event: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.enable[IDX_DAC] && !i_standby && !wr && !trip[IDX_DAC]) |=> o_reg_on[IDX_DAC])
        else $error("enabled regulator off without standby event");
    a_no_select_on: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.enable[IDX_GEN1] && !st.stby_sel[IDX_GEN1] && !wr && !trip[IDX_GEN1])
        |=> o_reg_on[IDX_GEN1])
        else $error("enabled regulator without select turned off");
    a_disabled_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !st.enable[IDX_GEN2] |-> !o_reg_on[IDX_GEN2] || $past(st.enable[IDX_GEN2]))
        else $error("disabled regulator on");

    a_internal_no_lp: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !(|(o_low_power & INTERNAL_PASS)))
        else $error("mode bit influenced internal pass regulator");
    a_lp_follows_dac: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.lp_mode[IDX_DAC] && st.enable[IDX_DAC] && !i_standby && !wr && !trip[IDX_DAC])
        |=> o_low_power[IDX_DAC])
        else $error("dac regulator ignored its mode bit");
    a_lp_clear_gen2: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!st.lp_mode[IDX_GEN2] && !wr) |=> !o_low_power[IDX_GEN2])
        else $error("general two in low power without mode bit");

    // a tripped regulator and its flag only change under software control
    a_stay_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!st.enable[IDX_DAC] && !(wr && i_bus.address == ADDR_ENABLE)) |=> !st.enable[IDX_DAC])
        else $error("tripped regulator came back by itself");
    a_stay_off_usb: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!st.enable[IDX_USB] && !(wr && i_bus.address == ADDR_ENABLE)) |=> !st.enable[IDX_USB])
        else $error("usb phy regulator came back by itself");
    a_stay_off_aux: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!st.enable[IDX_AUX] && !(wr && i_bus.address == ADDR_ENABLE)) |=> !st.enable[IDX_AUX])
        else $error("aux usb regulator came back by itself");
    a_stay_off_gen1: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!st.enable[IDX_GEN1] && !(wr && i_bus.address == ADDR_ENABLE))
        |=> !st.enable[IDX_GEN1])
        else $error("general one regulator came back by itself");
    a_stay_off_gen2: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!st.enable[IDX_GEN2] && !(wr && i_bus.address == ADDR_ENABLE))
        |=> !st.enable[IDX_GEN2])
        else $error("general two regulator came back by itself");
    a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.fault_flag[IDX_GEN1] && !(wr && i_bus.address == ADDR_STATUS))
        |=> st.fault_flag[IDX_GEN1])
        else $error("fault flag cleared without software");
    a_flag_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr && i_bus.address == ADDR_STATUS && i_bus.writedata[IDX_DAC] && !trip[IDX_DAC])
        |=> !st.fault_flag[IDX_DAC])
        else $error("fault flag not cleared by write");

    a_prot_reset: assert property (@(posedge i_clk) $rose(i_resetn) |-> !st.prot_en)
        else $error("protection enabled at reset");
    a_vsel_drive: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr && i_bus.address == ADDR_CTRL)
        |=> o_pll_vsel == lsp_vsel_type'($past(i_bus.writedata[CTRL_VSEL_LO +: 2])))
        else $error("pll select not driven");
    a_read_programmed: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (req && i_bus.read && i_bus.address == ADDR_ENABLE)
        |=> o_bus.readdata == 32'($past(st.enable)))
        else $error("enable read did not return programmed bits");

    // the bus answers after exactly one wait state and idles with zero data
    a_bus_one_wait: assert property (@(posedge i_clk) disable iff (!i_resetn)
        req |=> (!o_bus.waitrequest ##1 o_bus.waitrequest))
        else $error("bus answer not after one wait state");
    a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_bus.waitrequest |-> o_bus.readdata == '0)
        else $error("read data shown outside the answer cycle");

    c_trip: cover property (@(posedge i_clk) disable iff (!i_resetn) |trip);
    c_standby: cover property (@(posedge i_clk) disable iff (!i_resetn)
        i_standby && |(st.enable & st.stby_sel));
    c_masked_fault: cover property (@(posedge i_clk) disable iff (!i_resetn)
        |st.fault_flag && st.irq_mask);
    c_flag_clear: cover property (@(posedge i_clk) disable iff (!i_resetn)
        wr && i_bus.address == ADDR_STATUS && |st.fault_flag);
    c_low_power: cover property (@(posedge i_clk) disable iff (!i_resetn) |o_low_power);
endmodule
`default_nettype wire

/* dv/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lsp_pkg::*;
    logic i_clk;
    logic i_resetn;
    lsp_bus_req_type bus;
    lsp_bus_rsp_type rsp;
    logic i_standby;
    logic [5:0] i_fault;
    logic [5:0] reg_on;
    logic [5:0] low_power;
    lsp_vsel_type vsel;
    logic irq;
    logic [31:0] q;
    int n_errors;
    int checked;
    // short debounce keeps fault scenarios brief
    lsp_ldo_ctrl #(.DEBOUNCE(4)) u_lsp_ldo_ctrl (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_bus(bus), .o_bus(rsp), .i_standby(i_standby), .i_fault(i_fault),
        .o_reg_on(reg_on), .o_low_power(low_power), .o_pll_vsel(vsel), .o_irq(irq));
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic final_report();
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        bus <= '{address: a, read: !w, write: w, writedata: d};
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (rsp.waitrequest !== 1'b0 && n < 20);
        q = rsp.readdata;
        if (rsp.waitrequest !== 1'b0)
        begin
            n_errors++;
            $display("Error at %0t: bus timeout", $time);
            final_report();
        end
        bus.read <= 1'b0;
        bus.write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        cmp(q, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    initial
    begin
        int n;
        i_resetn = 1'b0;
        bus = '0;
        i_standby = 1'b0;
        i_fault = 6'h00;
        n_errors = 0;
        checked = 0;
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_ENABLE, 32'h0);
        wr(ADDR_ENABLE, 32'h3f);
        wr(ADDR_STBY, 32'h3f);
        tick(1);
        cmp(reg_on, 32'h3f);
        i_standby <= 1'b1;
        tick(2);
        cmp(reg_on, 32'h0);
        rd(ADDR_ENABLE, 32'h3f);
        wr(ADDR_CTRL, 32'h3f0);
        tick(1);
        cmp(reg_on & INTERNAL_PASS, 32'h0);
        wr(ADDR_STBY, 32'h0);
        tick(1);
        cmp(reg_on, 32'h3f);
        cmp(low_power, 32'h2a);
        i_standby <= 1'b0;
        for (int v = 0; v < 4; v++)
        begin
            wr(ADDR_CTRL, 32'(v) << 2);
            tick(1);
            cmp(vsel, 32'(v));
        end
        // protection still off: fault must be ignored
        i_fault <= 6'h02;
        tick(12);
        i_fault <= 6'h00;
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_ENABLE, 32'h3f);
        cmp(irq, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        i_fault <= 6'h02;
        tick(2);
        i_fault <= 6'h00;
        tick(8);
        rd(ADDR_STATUS, 32'h0);
        i_fault <= 6'h02;
        n = 0;
        while (reg_on[1] !== 1'b0 && n < 30)
        begin
            @(posedge i_clk);
            n++;
        end
        cmp(reg_on, 32'h3d);
        cmp(irq, 32'h1);
        if (n == 30)
        begin
            n_errors++;
            final_report();
        end
        i_fault <= 6'h00;
        rd(ADDR_ENABLE, 32'h3d);
        rd(ADDR_STATUS, 32'h2);
        wr(ADDR_CTRL, 32'h3);
        tick(1);
        cmp(irq, 32'h0);
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_ENABLE, 32'h3f);
        tick(1);
        cmp(reg_on, 32'h3f);
        i_fault <= 6'h3f;
        tick(10);
        i_fault <= 6'h00;
        rd(ADDR_ENABLE, 32'h1);
        rd(ADDR_STATUS, 32'h3e);
        rd(4'h2, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
